/* hdl/fbci_defs.svh */
// constants for the flash bus host controller
`ifndef FBCI_DEFS_SVH
`define FBCI_DEFS_SVH

// command codes
`define FBCI_CMD_ERASE_SETUP   8'h20
`define FBCI_CMD_ERASE_CONFIRM 8'hd0
`define FBCI_CMD_PROG_SETUP    8'h40
`define FBCI_CMD_PROG_SETUP_ALT 8'h10
`define FBCI_CMD_READ_ARRAY    8'hff
`define FBCI_CMD_IDENTIFY      8'h90

// bus cycle phase timing
`define FBCI_T_SETUP_NS   30
`define FBCI_T_STROBE_NS  80
`define FBCI_T_HOLD_NS    20
`define FBCI_CLK_NS       10
`define FBCI_SETUP_CYC  ((`FBCI_T_SETUP_NS + `FBCI_CLK_NS - 1) / `FBCI_CLK_NS)
`define FBCI_STROBE_CYC ((`FBCI_T_STROBE_NS + `FBCI_CLK_NS - 1) / `FBCI_CLK_NS)
`define FBCI_HOLD_CYC   ((`FBCI_T_HOLD_NS + `FBCI_CLK_NS - 1) / `FBCI_CLK_NS)

// identification address bits
`define FBCI_ID_SEL_BIT 0
`define FBCI_ID_HV_BIT  9

`endif

/* hdl/fbci_pkg.sv */
// types for the flash bus host controller
package fbci_pkg;

    typedef enum logic [3:0] {
        FBCI_OP_READ     = 4'h0,
        FBCI_OP_ID_READ  = 4'h1,
        FBCI_OP_IDENTIFY = 4'h2,
        FBCI_OP_READ_ARR = 4'h3,
        FBCI_OP_ERASE    = 4'h4,
        FBCI_OP_PROGRAM  = 4'h5,
        FBCI_OP_RESET    = 4'h6
    } fbci_op_t;

    typedef enum logic [4:0] {
        FBCI_C_IDLE   = 5'b00001,
        FBCI_C_SETUP  = 5'b00010,
        FBCI_C_STROBE = 5'b00100,
        FBCI_C_HOLD   = 5'b01000,
        FBCI_C_DONE   = 5'b10000
    } fbci_cyc_t;

endpackage

/* hdl/fbci_bus_cycle.sv */
// one timed read or write cycle on the flash pins
`timescale 1ns/1ps
`include "fbci_defs.svh"

module fbci_bus_cycle #(
    parameter int SETUP_CYC  = `FBCI_SETUP_CYC,
    parameter int STROBE_CYC = `FBCI_STROBE_CYC,
    parameter int HOLD_CYC   = `FBCI_HOLD_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // request
    input  wire logic        start,
    input  wire logic        is_write,
    // phase outputs
    output logic             strobe_on,
    output logic             sample,
    output logic             done
);

    // ***************************************************************
    // phase sequencer
    // ***************************************************************
    fbci_pkg::fbci_cyc_t st_q;
    logic [7:0]          cnt_q;
    logic                wr_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q  <= fbci_pkg::FBCI_C_IDLE;
            cnt_q <= 8'h00;
            wr_q  <= 1'b0;
        end else begin
            unique case (st_q)
                fbci_pkg::FBCI_C_IDLE: begin
                    if (start) begin
                        st_q  <= fbci_pkg::FBCI_C_SETUP;
                        cnt_q <= 8'(SETUP_CYC - 1);
                        wr_q  <= is_write;
                    end
                end
                fbci_pkg::FBCI_C_SETUP: begin
                    if (cnt_q == 8'h00) begin
                        st_q  <= fbci_pkg::FBCI_C_STROBE;
                        cnt_q <= 8'(STROBE_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbci_pkg::FBCI_C_STROBE: begin
                    if (cnt_q == 8'h00) begin
                        st_q  <= fbci_pkg::FBCI_C_HOLD;
                        cnt_q <= 8'(HOLD_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbci_pkg::FBCI_C_HOLD: begin
                    if (cnt_q == 8'h00) begin
                        st_q <= fbci_pkg::FBCI_C_DONE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbci_pkg::FBCI_C_DONE: begin
                    st_q <= fbci_pkg::FBCI_C_IDLE;
                end
                default: begin
                    st_q <= fbci_pkg::FBCI_C_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        strobe_on = (st_q == fbci_pkg::FBCI_C_STROBE);
        // read data is taken at the end of the strobe, before it rises
        sample    = strobe_on && (cnt_q == 8'h00) && !wr_q;
        done      = (st_q == fbci_pkg::FBCI_C_DONE);
    end

endmodule

/* hdl/fbci_host.sv */
// host controller driving the flash command and bus interface pins
//
// Summary of operation
// - erase confirm D0h is sent only right after erase setup 20h.
// - program data is sent only right after program setup 40h.
// - after program or erase the host raises rsp_need_read_array until a read array FFh op or a reset op.
// - during id read all address bits except A0 are low; A9 stays low too and flash_id_hv is raised instead.
`timescale 1ns/1ps
`include "fbci_defs.svh"

module fbci_host #(
    parameter int ADDR_W     = 18,
    parameter int SETUP_CYC  = `FBCI_SETUP_CYC,
    parameter int STROBE_CYC = `FBCI_STROBE_CYC,
    parameter int HOLD_CYC   = `FBCI_HOLD_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // user request
    input  wire logic              req_valid,
    input  wire fbci_pkg::fbci_op_t req_op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [15:0]       req_wdata,
    input  wire logic              req_byte_mode,
    input  wire logic              req_byte_hi,
    input  wire logic              req_boot_unlock,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [15:0]            rsp_rdata,
    output logic                   rsp_need_read_array,
    // flash control pins
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic                   reset_powerdown_n,
    output logic                   boot_unlock_voltage,
    output logic                   flash_wp,
    output logic                   flash_byte_n,
    output logic                   flash_id_hv,
    // flash address and data pins
    output logic [ADDR_W-1:0]      flash_addr,
    input  wire logic [15:0]       flash_dq_i,
    output logic [15:0]            flash_dq_o,
    output logic [15:0]            flash_dq_oe
);

    // ***************************************************************
    // input synchroniser for the data pins
    // ***************************************************************
    logic [15:0] dq_s1_q;
    logic [15:0] dq_s2_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= flash_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // ***************************************************************
    // bus cycle timer
    // ***************************************************************
    logic cyc_start;
    logic cyc_write;
    logic strobe_on;
    logic sample;
    logic cyc_done;

    fbci_bus_cycle #(
        .SETUP_CYC  (SETUP_CYC),
        .STROBE_CYC (STROBE_CYC),
        .HOLD_CYC   (HOLD_CYC)
    ) u_cycle (
        .clk       (clk),
        .rst_n     (rst_n),
        .start     (cyc_start),
        .is_write  (cyc_write),
        .strobe_on (strobe_on),
        .sample    (sample),
        .done      (cyc_done)
    );

    // ***************************************************************
    // operation sequencer
    // ***************************************************************
    fbci_pkg::fbci_op_t op_q;
    logic              busy_q;
    logic              issued_q;
    logic              second_q;
    logic              wr_q;
    logic [ADDR_W-1:0] addr_q;
    logic [15:0]       wdata_q;
    logic [15:0]       cmd_q;
    logic              byte_q;
    logic              bhi_q;
    logic              unlock_q;
    logic              dirty_q;

    // erase and program are two cycles: setup then confirm or data
    logic two_cycle;
    assign two_cycle = (op_q == fbci_pkg::FBCI_OP_ERASE) || (op_q == fbci_pkg::FBCI_OP_PROGRAM);

    assign cyc_start = busy_q && !issued_q && (op_q != fbci_pkg::FBCI_OP_RESET);
    assign cyc_write = wr_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_q     <= fbci_pkg::FBCI_OP_READ;
            busy_q   <= 1'b0;
            issued_q <= 1'b0;
            second_q <= 1'b0;
            wr_q     <= 1'b0;
            addr_q   <= '0;
            wdata_q  <= 16'h0000;
            cmd_q    <= 16'h0000;
            byte_q   <= 1'b0;
            bhi_q    <= 1'b0;
            unlock_q <= 1'b0;
        end else if (!busy_q) begin
            if (req_valid) begin
                busy_q   <= 1'b1;
                issued_q <= 1'b0;
                second_q <= 1'b0;
                op_q     <= req_op;
                addr_q   <= req_addr;
                wdata_q  <= req_wdata;
                byte_q   <= req_byte_mode;
                bhi_q    <= req_byte_hi;
                unlock_q <= req_boot_unlock;
                unique case (req_op)
                    fbci_pkg::FBCI_OP_ERASE: begin
                        cmd_q <= {8'h00, `FBCI_CMD_ERASE_SETUP};
                        wr_q  <= 1'b1;
                    end
                    fbci_pkg::FBCI_OP_PROGRAM: begin
                        cmd_q <= {8'h00, `FBCI_CMD_PROG_SETUP};
                        wr_q  <= 1'b1;
                    end
                    fbci_pkg::FBCI_OP_IDENTIFY: begin
                        cmd_q <= {8'h00, `FBCI_CMD_IDENTIFY};
                        wr_q  <= 1'b1;
                    end
                    fbci_pkg::FBCI_OP_READ_ARR: begin
                        cmd_q <= {8'h00, `FBCI_CMD_READ_ARRAY};
                        wr_q  <= 1'b1;
                    end
                    default: begin
                        cmd_q <= 16'h0000;
                        wr_q  <= 1'b0;
                    end
                endcase
            end
        end else if (op_q == fbci_pkg::FBCI_OP_RESET) begin
            // the reset op holds the pin low for two clock cycles
            issued_q <= 1'b1;
            if (issued_q) begin
                busy_q <= 1'b0;
            end
        end else begin
            if (cyc_start) begin
                issued_q <= 1'b1;
            end
            if (cyc_done) begin
                if (two_cycle && !second_q) begin
                    // second cycle follows the setup with nothing between
                    second_q <= 1'b1;
                    issued_q <= 1'b0;
                    if (op_q == fbci_pkg::FBCI_OP_ERASE) begin
                        cmd_q <= {8'h00, `FBCI_CMD_ERASE_CONFIRM};
                    end else begin
                        cmd_q <= wdata_q;
                    end
                end else begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // after a program or erase, array reads return status until FFh or a reset op
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dirty_q <= 1'b0;
        end else if (busy_q && op_q == fbci_pkg::FBCI_OP_RESET) begin
            dirty_q <= 1'b0;
        end else if (cyc_done && two_cycle && second_q) begin
            dirty_q <= 1'b1;
        end else if (cyc_done && op_q == fbci_pkg::FBCI_OP_READ_ARR) begin
            dirty_q <= 1'b0;
        end
    end

    // ***************************************************************
    // pin drive, every output registered
    // ***************************************************************
    logic id_read;
    logic in_cycle;
    logic boot_op;
    assign id_read  = (op_q == fbci_pkg::FBCI_OP_ID_READ);
    assign in_cycle = busy_q && issued_q && !cyc_done;
    assign boot_op  = busy_q && two_cycle && unlock_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flash_ce_n          <= 1'b1;
            flash_oe_n          <= 1'b1;
            flash_we_n          <= 1'b1;
            reset_powerdown_n   <= 1'b0;
            boot_unlock_voltage <= 1'b0;
            flash_wp            <= 1'b0;
            flash_byte_n        <= 1'b1;
            flash_id_hv         <= 1'b0;
            flash_addr          <= '0;
            flash_dq_o          <= 16'h0000;
            flash_dq_oe         <= 16'h0000;
        end else begin
            reset_powerdown_n   <= !(busy_q && op_q == fbci_pkg::FBCI_OP_RESET);
            boot_unlock_voltage <= boot_op;
            flash_wp            <= boot_op;
            flash_ce_n          <= !in_cycle;
            flash_oe_n          <= !(in_cycle && !wr_q);
            flash_we_n          <= !(in_cycle && wr_q && strobe_on);
            flash_byte_n        <= !byte_q;
            flash_id_hv         <= busy_q && id_read;
            if (id_read) begin
                flash_addr <= '0;
                flash_addr[`FBCI_ID_SEL_BIT] <= addr_q[`FBCI_ID_SEL_BIT];
            end else begin
                flash_addr <= addr_q;
            end
            if (byte_q) begin
                // the top line is the byte address on reads too, so it is driven then as well
                flash_dq_o  <= {bhi_q, 7'h00, cmd_q[7:0]};
                flash_dq_oe <= !in_cycle ? 16'h0000 : (wr_q ? 16'h80ff : 16'h8000);
            end else begin
                flash_dq_o  <= cmd_q;
                flash_dq_oe <= (in_cycle && wr_q) ? 16'hffff : 16'h0000;
            end
        end
    end

    // ***************************************************************
    // user side answers
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            req_ready <= 1'b0;
            rsp_need_read_array <= 1'b0;
        end else begin
            req_ready <= !busy_q && !req_valid;
            rsp_need_read_array <= dirty_q;
            rsp_valid <= busy_q && cyc_done && (!two_cycle || second_q);
            if (sample) begin
                // byte mode: lines 14:8 float and line 15 carries the byte address, keep only the low byte
                rsp_rdata <= byte_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
            end
        end
    end

endmodule

/* verif/fbci_host_chk.sv */
// pin-level checker for the flash bus host controller
`timescale 1ns/1ps
module fbci_host_chk #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // flash pins
    input wire logic              flash_ce_n,
    input wire logic              flash_oe_n,
    input wire logic              flash_we_n,
    input wire logic              reset_powerdown_n,
    input wire logic              flash_byte_n,
    input wire logic              flash_id_hv,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [15:0]       flash_dq_o,
    input wire logic [15:0]       flash_dq_oe
);
    // ************
    // write history
    // ************
    // a setup code opens a pair; the very next write closes it
    logic       pend_q;
    logic [7:0] code_q;
    logic       we_q;
    always_ff @(posedge clk) begin
        we_q <= flash_we_n;
        if (!rst_n || !reset_powerdown_n) begin
            pend_q <= 1'b0;
            code_q <= 8'h00;
        end else if (flash_we_n && !we_q) begin
            pend_q <= !pend_q && (flash_dq_o[7:0] inside {8'h20, 8'h40, 8'h10});
            code_q <= flash_dq_o[7:0];
        end
    end
    // ************
    // properties
    // ************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_strobe;
        !flash_we_n [*8] ##1 flash_we_n;
    endsequence
    sequence s_erase_open;
        $fell(flash_we_n) && pend_q && code_q == 8'h20;
    endsequence
    property p_strobe;       $fell(flash_we_n) |-> s_strobe;                      endproperty
    property p_confirm;      s_erase_open |-> flash_dq_o[7:0] == 8'hd0;           endproperty
    property p_no_split;     $fell(flash_oe_n) |-> !pend_q;                       endproperty
    property p_excl;         !(!flash_oe_n && !flash_we_n);                       endproperty
    property p_we_ce;        !flash_we_n |-> !flash_ce_n;                         endproperty
    property p_oe_ce;        !flash_oe_n |-> !flash_ce_n;                         endproperty
    property p_read_release; !flash_oe_n |-> flash_dq_oe[14:0] == 15'h0000;       endproperty
    property p_write_drive;  !flash_we_n |-> flash_dq_oe[7:0] == 8'hff;           endproperty
    property p_byte_hi;      !flash_byte_n |-> flash_dq_oe[14:8] == 7'h00;        endproperty
    property p_id_addr;
        flash_id_hv && !flash_oe_n |-> flash_addr[8:1] == 8'h00 && flash_addr[ADDR_W-1:10] == '0;
    endproperty
    a_strobe:       assert property (p_strobe) else $error("write strobe length wrong");
    a_confirm:      assert property (p_confirm) else $error("erase setup not confirmed");
    a_no_split:     assert property (p_no_split) else $error("read inside command pair");
    a_excl:         assert property (p_excl) else $error("oe and we low together");
    a_we_ce:        assert property (p_we_ce) else $error("write without chip select");
    a_oe_ce:        assert property (p_oe_ce) else $error("read without chip select");
    a_read_release: assert property (p_read_release) else $error("host drives during read");
    a_write_drive:  assert property (p_write_drive) else $error("write data not driven");
    a_byte_hi:      assert property (p_byte_hi) else $error("upper lines driven in byte mode");
    a_id_addr:      assert property (p_id_addr) else $error("id read address not clear");
endmodule

bind fbci_host fbci_host_chk #(.ADDR_W(ADDR_W)) i_fbci_host_chk (.clk, .rst_n, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .reset_powerdown_n, .flash_byte_n, .flash_id_hv, .flash_addr,
    .flash_dq_o, .flash_dq_oe);

/* verif/fbci_flash_model.sv */
// behavioural model of the flash device on the far side of the bus
`timescale 1ns/1ps
module fbci_flash_model #(
    parameter logic [7:0]  ID_MFR    = 8'h3c, // arbitrary value
    parameter logic [7:0]  ID_DEV    = 8'h5e, // arbitrary value
    parameter logic [7:0]  ID_HI     = 8'ha1, // arbitrary value
    parameter logic [17:0] BOOT_BASE = 18'h3e000,
    parameter bit          VPP_OK    = 1'b1
) (
    // control pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rp_n,
    input  wire logic        unlock,
    input  wire logic        wp,
    input  wire logic        byte_n,
    input  wire logic        id_hv,
    // address and data
    input  wire logic [17:0] addr,
    input  wire logic [15:0] dq,
    output logic [15:0]      dq_o,
    output logic [15:0]      dq_oe
);
    logic [15:0] mem [logic [17:0]];
    logic [1:0]  pend = 2'd0;
    logic [1:0]  rmode = 2'd0;
    logic [15:0] w;
    logic [7:0]  b;
    logic        ok;
    logic        idm;
    // ************
    // command writes
    // ************
    always @(posedge we_n or negedge rp_n) begin
        ok = VPP_OK && (addr < BOOT_BASE || unlock || wp);
        if (!rp_n) begin
            pend = 2'd0;
            rmode = 2'd0;
        end else if (!ce_n && pend == 2'd2) begin
            if (ok) mem[addr] = dq;
            rmode = 2'd2;
            pend = 2'd0;
        end else if (!ce_n && pend == 2'd1) begin
            if (ok && dq[7:0] == 8'hd0) begin
                foreach (mem[k]) begin
                    if (k[17:13] == addr[17:13]) mem[k] = 16'hffff;
                end
            end
            rmode = 2'd2;
            pend = 2'd0;
        end else if (!ce_n) begin
            case (dq[7:0])
                8'h20: pend = 2'd1;
                8'h40, 8'h10: pend = 2'd2;
                8'hff: rmode = 2'd0;
                8'h90: rmode = 2'd1;
                default: ;
            endcase
        end
    end
    // ************
    // read path
    // ************
    // undriven lines show the inverse word so a float never reads back as data
    always @* begin
        idm = id_hv || rmode == 2'd1;
        if (idm) w = addr[0] ? {ID_HI, ID_DEV} : {8'h00, ID_MFR};
        else if (rmode == 2'd2) w = 16'h0080;
        else w = mem.exists(addr) ? mem[addr] : 16'hffff;
        b = (dq[15] && !idm) ? w[15:8] : w[7:0];
        if (!(rp_n && !ce_n && !oe_n && we_n)) dq_oe = 16'h0000;
        else dq_oe = byte_n ? 16'hffff : 16'h00ff;
        dq_o = (dq_oe & (byte_n ? w : {8'h00, b})) | (~dq_oe & ~w);
    end
endmodule

/* verif/test_flash_bus_command_interface.sv */
// self-checking testbench for the flash bus host controller
`timescale 1ns/1ps
module test_flash_bus_command_interface;
    localparam logic [7:0] ID_MFR = 8'h3c; // arbitrary value
    localparam logic [7:0] ID_DEV = 8'h5e; // arbitrary value
    localparam logic [7:0] ID_HI  = 8'ha1; // arbitrary value
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_byte_mode = 1'b0, req_byte_hi = 1'b0;
    logic req_boot_unlock = 1'b0, req_ready, rsp_valid, rsp_need_read_array, hi_seen = 1'b0;
    fbci_pkg::fbci_op_t req_op = fbci_pkg::FBCI_OP_READ;
    logic [17:0] req_addr = 18'h00000, flash_addr;
    logic [15:0] req_wdata = 16'h0000, rsp_rdata, flash_dq_i, h_o, h_oe, d_o, d_oe;
    logic ce_n, oe_n, we_n, rp_n, ul, wp, byte_n, id_hv;
    int n_mismatch = 0, n_compared = 0;
    fbci_host i_fbci_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_mode(req_byte_mode),
        .req_byte_hi(req_byte_hi), .req_boot_unlock(req_boot_unlock), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_need_read_array(rsp_need_read_array),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .reset_powerdown_n(rp_n),
        .boot_unlock_voltage(ul), .flash_wp(wp), .flash_byte_n(byte_n), .flash_id_hv(id_hv),
        .flash_addr(flash_addr), .flash_dq_i(flash_dq_i), .flash_dq_o(h_o), .flash_dq_oe(h_oe));
    fbci_flash_model #(.ID_MFR(ID_MFR), .ID_DEV(ID_DEV), .ID_HI(ID_HI)) i_fbci_flash_model (
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .unlock(ul), .wp(wp),
        .byte_n(byte_n), .id_hv(id_hv), .addr(flash_addr), .dq(flash_dq_i), .dq_o(d_o),
        .dq_oe(d_oe));
    assign flash_dq_i = (h_oe & h_o) | (~h_oe & d_o);
    always @(posedge clk) if (!byte_n && d_oe[14:8] !== 7'h00) hi_seen <= 1'b1;
    initial forever #5 clk = ~clk;
    task test_done;
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request, then a bounded wait for its answer (reset has none)
    task run(input fbci_pkg::fbci_op_t op, input logic [17:0] a, input logic [15:0] d);
        int i;
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        if (op == fbci_pkg::FBCI_OP_RESET) repeat (3) @(posedge clk);
        for (i = 0; i < 400; i++) begin
            if ((op == fbci_pkg::FBCI_OP_RESET ? req_ready : rsp_valid) === 1'b1) break;
            @(posedge clk);
        end
        if (i >= 400) begin
            n_mismatch++;
            test_done();
        end
    endtask
    task t_program;
        run(fbci_pkg::FBCI_OP_PROGRAM, 18'h00005, 16'h1234);
        // the flag follows the answer by one edge, as it is re-registered
        @(posedge clk);
        chk(rsp_need_read_array, 16'h0001);
        run(fbci_pkg::FBCI_OP_READ, 18'h00005, 16'h0000);
        chk(rsp_rdata, 16'h0080);
        run(fbci_pkg::FBCI_OP_READ_ARR, 18'h00000, 16'h0000);
        @(posedge clk);
        chk(rsp_need_read_array, 16'h0000);
        run(fbci_pkg::FBCI_OP_READ, 18'h00005, 16'h0000);
        chk(rsp_rdata, 16'h1234);
    endtask
    task t_byte;
        req_byte_mode <= 1'b1;
        req_byte_hi <= 1'b1;
        run(fbci_pkg::FBCI_OP_READ, 18'h00005, 16'h0000);
        chk(rsp_rdata[7:0], 16'h0012);
        req_byte_hi <= 1'b0;
        run(fbci_pkg::FBCI_OP_READ, 18'h00005, 16'h0000);
        chk(rsp_rdata[7:0], 16'h0034);
        run(fbci_pkg::FBCI_OP_ID_READ, 18'h00001, 16'h0000);
        chk(rsp_rdata[7:0], {8'h00, ID_DEV});
        chk(hi_seen, 16'h0000);
        req_byte_mode <= 1'b0;
    endtask
    task t_erase;
        run(fbci_pkg::FBCI_OP_ERASE, 18'h00005, 16'h0000);
        run(fbci_pkg::FBCI_OP_READ_ARR, 18'h00000, 16'h0000);
        run(fbci_pkg::FBCI_OP_READ, 18'h00005, 16'h0000);
        chk(rsp_rdata, 16'hffff);
    endtask
    task t_boot(input logic u, input logic [15:0] exp);
        req_boot_unlock <= u;
        run(fbci_pkg::FBCI_OP_PROGRAM, 18'h3e010, 16'h5a5a);
        run(fbci_pkg::FBCI_OP_READ_ARR, 18'h00000, 16'h0000);
        run(fbci_pkg::FBCI_OP_READ, 18'h3e010, 16'h0000);
        chk(rsp_rdata, exp);
        req_boot_unlock <= 1'b0;
    endtask
    task t_id;
        run(fbci_pkg::FBCI_OP_ID_READ, 18'h3fe00, 16'h0000);
        chk(rsp_rdata, {8'h00, ID_MFR});
        run(fbci_pkg::FBCI_OP_ID_READ, 18'h00001, 16'h0000);
        chk(rsp_rdata, {ID_HI, ID_DEV});
        run(fbci_pkg::FBCI_OP_IDENTIFY, 18'h00000, 16'h0000);
        run(fbci_pkg::FBCI_OP_READ, 18'h00001, 16'h0000);
        chk(rsp_rdata, {ID_HI, ID_DEV});
        run(fbci_pkg::FBCI_OP_READ_ARR, 18'h00000, 16'h0000);
    endtask
    task t_reset;
        run(fbci_pkg::FBCI_OP_PROGRAM, 18'h00006, 16'hbeef);
        run(fbci_pkg::FBCI_OP_RESET, 18'h00000, 16'h0000);
        run(fbci_pkg::FBCI_OP_READ, 18'h00006, 16'h0000);
        chk(rsp_rdata, 16'hbeef);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_program();
        t_byte();
        t_erase();
        t_boot(1'b0, 16'hffff);
        t_boot(1'b1, 16'h5a5a);
        t_id();
        t_reset();
        test_done();
    end
endmodule
